// >>> src/ats_sequencer.sv
// Function
// - seven timing signals each pick external source
// - star trigger line is never driven
// - per-input polarity and edge or level
// - start edge begins both sequence modes
// - start trigger can drive function pin or bus
// - start output pulse 50-100 ns, actual event
// - all outputs undriven until configured
// - pretrigger start from software unless pin chosen
// - reference edge from any source starts posttrigger
// - counter first counts minimum pretrigger scans
// - counter reloads posttrigger count, acquisition continues
// - reference edges before counter zero are ignored
// - exactly posttrigger scans after reference, then stop
// - pretrigger data includes before and after scans
// - reference output pulse 50-100 ns at posttrigger
// - reference unused in posttriggered acquisitions
// - scan clock counter started by start, stopped
// - scans inhibited outside an active sequence
module ats_sequencer
    import ats_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    // raw external pins
    input wire logic func_in_i,
    input wire logic [ats_pkg::BUS_LINES-1:0] bus_i,
    input wire logic star_i,
    // routing per timing signal, packed 3 bits each
    input wire logic [ats_pkg::TIMING_SIGNALS*3-1:0] src_sel,
    input wire logic [ats_pkg::TIMING_SIGNALS-1:0] src_ext,
    input wire logic [ats_pkg::TIMING_SIGNALS-1:0] src_invert,
    input wire logic [ats_pkg::TIMING_SIGNALS-1:0] src_level,
    // sequence control
    input wire logic pretrig_mode,
    input wire logic sw_start,
    input wire logic sw_stop,
    input wire logic [ats_pkg::CNT_W-1:0] pre_scans,
    input wire logic [ats_pkg::CNT_W-1:0] post_scans,
    input wire logic scan_tick,
    // output routing
    input wire logic [2:0] start_out_sel,
    input wire logic ref_out_bus_en,
    input wire logic [2:0] ref_out_line,
    // pins driven
    output logic func_in_o,
    output logic func_in_oe,
    output logic [ats_pkg::BUS_LINES-1:0] bus_o,
    output logic [ats_pkg::BUS_LINES-1:0] bus_oe,
    // status and internal timing
    output logic seq_active,
    output logic scan_enable,
    output logic scan_strobe,
    output logic ref_accepted,
    output logic seq_done,
    output logic [ats_pkg::CNT_W-1:0] scan_count,
    output logic [ats_pkg::TIMING_SIGNALS-1:0] timing_sig
);
    import ats_pkg::*;

    // two-stage synchronisers for all eight external sources
    logic [SRC_COUNT-1:0] sync1_reg;
    logic [SRC_COUNT-1:0] sync2_reg;
    logic [SRC_COUNT-1:0] raw_pins;
    // conditioned level and previous level per timing signal
    logic [TIMING_SIGNALS-1:0] cond_lvl;
    logic [TIMING_SIGNALS-1:0] prev_reg;
    logic [TIMING_SIGNALS-1:0] edge_evt;
    // sequencer state and scan counter
    ats_state_t state_reg;
    ats_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    // pulse width counters for start and reference outputs
    logic [PW_W-1:0] start_pw_reg;
    logic [PW_W-1:0] ref_pw_reg;
    // sequence events
    logic start_evt;
    logic ref_evt;
    logic scan_evt;
    logic stop_evt;

    // pick source bit for a selector code
    function automatic logic pick_src(input logic [2:0] sel,
                                      input logic [SRC_COUNT-1:0] v);
        pick_src = v[sel];
    endfunction : pick_src

    // bus line one-hot for a line code
    function automatic logic [BUS_LINES-1:0] line_hot(input logic [2:0] l);
        line_hot = (l < 3'(BUS_LINES)) ? 6'(6'h01 << l) : 6'h00;
    endfunction : line_hot

    // order: function input, bus 0..5, star
    assign raw_pins = {star_i, bus_i, func_in_i};

    // synchronise every external input before use
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
        end
    end

    // route and condition each timing signal
    always_comb
    begin
        for (int i = 0; i < TIMING_SIGNALS; i++)
        begin
            // source chosen per signal, polarity applied
            cond_lvl[i] = src_ext[i]
                && (pick_src(src_sel[i*3 +: 3], sync2_reg)
                ^ src_invert[i]);
        end
    end

    // remember previous conditioned level
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            prev_reg <= '0;
        else
            prev_reg <= cond_lvl;
    end

    // one-cycle event per active edge
    assign edge_evt = cond_lvl & ~prev_reg;

    // internal timing copies: edge pulse or level per setting
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            timing_sig <= '0;
        else
            timing_sig <= (src_level & cond_lvl)
                | (~src_level & edge_evt);
    end

    // start comes from pin edge, else software command
    assign start_evt = src_ext[SIG_START] ? edge_evt[SIG_START]
                                          : sw_start;
    // reference only honoured in pretrigger armed state
    assign ref_evt = edge_evt[SIG_REF] && pretrig_mode
                     && (state_reg == ATS_ARMED);
    // scan tick counts only inside a sequence
    assign scan_evt = scan_tick && (state_reg != ATS_IDLE);
    assign stop_evt = sw_stop;

    // sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ATS_IDLE:
            begin
                if (start_evt)
                    state_next = pretrig_mode ? ATS_PRE : ATS_POST;
            end
            ATS_PRE:
            begin
                // minimum pretrigger scans then arm
                if (stop_evt)
                    state_next = ATS_IDLE;
                else if (cnt_reg == '0 || (scan_evt && cnt_reg == 1))
                    state_next = ATS_ARMED;
            end
            ATS_ARMED:
            begin
                // keep scanning until reference accepted
                if (stop_evt)
                    state_next = ATS_IDLE;
                else if (ref_evt)
                    state_next = ATS_POST;
            end
            ATS_POST:
            begin
                if (stop_evt)
                    state_next = ATS_IDLE;
                else if (cnt_reg == '0 || (scan_evt && cnt_reg == 1))
                    state_next = ATS_IDLE;
            end
            default:
                state_next = ATS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            state_reg <= ATS_IDLE;
        else
            state_reg <= state_next;
    end

    // scan counter load and decrement
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            cnt_reg <= CNT_RESET;
        else if (state_reg == ATS_IDLE && start_evt)
            cnt_reg <= pretrig_mode ? pre_scans : post_scans;
        else if (state_reg == ATS_PRE && state_next == ATS_ARMED)
            cnt_reg <= post_scans;
        else if (state_reg == ATS_ARMED)
            cnt_reg <= post_scans;
        else if (scan_evt && cnt_reg != '0
                 && state_reg != ATS_ARMED)
            cnt_reg <= cnt_reg - 1'b1;
    end

    // status outputs from flip-flops
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            seq_active <= 1'b0;
            scan_enable <= 1'b0;
            scan_strobe <= 1'b0;
            ref_accepted <= 1'b0;
            seq_done <= 1'b0;
            scan_count <= CNT_RESET;
        end
        else
        begin
            seq_active <= state_next != ATS_IDLE;
            scan_enable <= state_next != ATS_IDLE;
            scan_strobe <= scan_evt;
            ref_accepted <= ref_evt;
            seq_done <= state_reg != ATS_IDLE && state_next == ATS_IDLE;
            scan_count <= cnt_reg;
        end
    end

    // start output pulse width counter, fires on actual start
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            start_pw_reg <= '0;
        else if (state_reg == ATS_IDLE && start_evt)
            start_pw_reg <= PULSE_LEN;
        else if (start_pw_reg != '0)
            start_pw_reg <= start_pw_reg - 1'b1;
    end

    // reference output pulse width counter
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            ref_pw_reg <= '0;
        else if (ref_evt)
            ref_pw_reg <= PULSE_LEN;
        else if (ref_pw_reg != '0)
            ref_pw_reg <= ref_pw_reg - 1'b1;
    end

    // function pin driver: only start trigger may use it
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            func_in_o <= 1'b0;
            func_in_oe <= 1'b0;
        end
        else
        begin
            func_in_oe <= start_out_sel == OUT_FUNC_IN;
            func_in_o <= start_pw_reg != '0;
        end
    end

    // bus drivers; star has no driver at all
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            bus_o <= '0;
            bus_oe <= '0;
        end
        else
        begin
            // start on chosen line, reference only when pretriggered
            bus_oe <= ((start_out_sel >= OUT_BUS0)
                ? line_hot(3'(start_out_sel - OUT_BUS0)) : 6'h00)
                | ((ref_out_bus_en && pretrig_mode)
                ? line_hot(ref_out_line) : 6'h00);
            bus_o <= ((start_out_sel >= OUT_BUS0 && start_pw_reg != '0)
                ? line_hot(3'(start_out_sel - OUT_BUS0)) : 6'h00)
                | ((ref_pw_reg != '0)
                ? line_hot(ref_out_line) : 6'h00);
        end
    end
endmodule : ats_sequencer

// >>> common/ats_pkg.sv
package ats_pkg;
    // number of external trigger sources: function input, bus 0..5, star
    localparam int SRC_COUNT = 8;
    localparam int SRC_W = 3;
    // source selector codes
    localparam logic [2:0] SRC_FUNC_IN = 3'h0;
    localparam logic [2:0] SRC_BUS0 = 3'h1;
    localparam logic [2:0] SRC_STAR = 3'h7;
    // bus lines the block can drive
    localparam int BUS_LINES = 6;
    // count of internal timing signals routed from outside
    localparam int TIMING_SIGNALS = 7;
    // indices of routed timing signals
    localparam int SIG_START = 0;
    localparam int SIG_REF = 1;
    localparam int SIG_SCAN = 2;
    localparam int SIG_CONV = 3;
    localparam int SIG_PAUSE = 4;
    localparam int SIG_TBASE = 5;
    localparam int SIG_HOLD = 6;
    // output route codes for start trigger
    localparam logic [2:0] OUT_NONE = 3'h0;
    localparam logic [2:0] OUT_FUNC_IN = 3'h1;
    localparam logic [2:0] OUT_BUS0 = 3'h2;
    // scan counter width
    localparam int CNT_W = 32;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    // output pulse timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_MIN_NS = 50;
    localparam int PULSE_MAX_NS = 100;
    localparam int PULSE_MIN_CYC =
        (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
    // pulse held for the minimum width plus margin, inside the window
    localparam int PULSE_CYC = (PULSE_MIN_CYC + PULSE_MAX_CYC) / 2;
    localparam int PW_W = 5;
    localparam logic [4:0] PULSE_LEN = 5'(PULSE_CYC);
    // sequencer states, gray coded along the usual path
    typedef enum logic [1:0] {
        ATS_IDLE = 2'b00,
        ATS_PRE = 2'b01,
        ATS_ARMED = 2'b11,
        ATS_POST = 2'b10
    } ats_state_t;
endpackage : ats_pkg

// >>> test/ats_sequencer_sva.sv
// protocol checks on the sequencer pins
module ats_sequencer_sva
    import ats_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ats_pkg::TIMING_SIGNALS-1:0] src_ext,
    input wire logic pretrig_mode,
    input wire logic sw_start,
    input wire logic scan_tick,
    input wire logic [2:0] start_out_sel,
    input wire logic ref_out_bus_en,
    input wire logic [2:0] ref_out_line,
    input wire logic func_in_o,
    input wire logic func_in_oe,
    input wire logic [ats_pkg::BUS_LINES-1:0] bus_oe,
    input wire logic seq_active,
    input wire logic scan_strobe,
    input wire logic ref_accepted,
    input wire logic seq_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [4:0] hi_cnt; // high cycles of start pin pulse
    // count consecutive high samples of the pin
    always_ff @(posedge mclk)
    begin
        if (!nrst || !func_in_o)
            hi_cnt <= 5'h00;
        else
            hi_cnt <= hi_cnt + 5'h01;
    end
    a_oe_after_reset:
        assert property ($rose(nrst) |-> !func_in_oe && bus_oe == 6'h00)
        else $error("enable high after reset");
    a_oe_unselected:
        assert property ($past(start_out_sel) == OUT_NONE
            && !$past(ref_out_bus_en) |-> !func_in_oe && bus_oe == 6'h00)
        else $error("pin driven while unselected");
    a_start_pin_oe:
        assert property ($past(nrst) && $past(start_out_sel) == OUT_FUNC_IN
            |-> func_in_oe)
        else $error("start pin not enabled");
    a_ref_bus_oe:
        assert property ($past(nrst) && $past(ref_out_bus_en)
            && $past(pretrig_mode) && $past(ref_out_line) == 3'h3
            |-> bus_oe[3])
        else $error("reference bus line not enabled");
    a_sw_start_run:
        assert property (sw_start && !src_ext[SIG_START] && !seq_active
            |=> seq_active)
        else $error("software start not taken");
    a_start_pulse:
        assert property (sw_start && !src_ext[SIG_START] && !seq_active
            && start_out_sel == OUT_FUNC_IN |-> ##2 func_in_o)
        else $error("start pulse late");
    a_pulse_width:
        assert property ($fell(func_in_o) |-> hi_cnt == PULSE_LEN)
        else $error("start pulse width wrong");
    a_ref_pre_only:
        assert property (ref_accepted |-> pretrig_mode && seq_active)
        else $error("reference outside pretrigger");
    a_strobe_tick:
        assert property (scan_strobe |-> $past(scan_tick))
        else $error("strobe without tick");
    // a new start may follow at once, so only the end cycle is idle
    a_done_single:
        assert property (seq_done |-> !seq_active ##1 !seq_done)
        else $error("done not a single end pulse");
    c_ref: cover property (ref_accepted);
    c_done: cover property (seq_done);
    c_start: cover property ($rose(func_in_o));
endmodule : ats_sequencer_sva

bind ats_sequencer ats_sequencer_sva ats_sequencer_sva_inst (.mclk, .nrst,
    .src_ext, .pretrig_mode, .sw_start, .scan_tick, .start_out_sel,
    .ref_out_bus_en, .ref_out_line, .func_in_o, .func_in_oe, .bus_oe,
    .seq_active, .scan_strobe, .ref_accepted, .seq_done);

// >>> test/ats_trig_src.sv
// external trigger sources on the far side
module ats_trig_src (
    input wire logic mclk,
    input wire logic fire,
    input wire logic [2:0] fire_src,
    input wire logic [3:0] fire_len,
    input wire logic idle_hi,
    output logic func_in_i,
    output logic [5:0] bus_i,
    output logic star_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] src_reg = 3'h0; // pin being pulsed
    logic [3:0] left_reg = 4'h0; // cycles of pulse left
    // hold chosen pin active for fire_len cycles
    always @(posedge mclk)
    begin
        if (fire)
        begin
            src_reg <= fire_src;
            left_reg <= fire_len;
        end
        else if (left_reg != 4'h0)
            left_reg <= left_reg - 4'h1;
    end
    // star is driven only from this side
    assign {star_i, bus_i, func_in_i} = {8{idle_hi}} ^
        ((left_reg != 4'h0) ? (8'h01 << src_reg) : 8'h00);
endmodule : ats_trig_src

// >>> test/ats_sequencer_test.sv
module ats_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ats_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [20:0] src_sel = 21'h000000;
    logic [6:0] src_ext = 7'h00;
    logic [6:0] src_invert = 7'h00;
    logic [6:0] src_level = 7'h00;
    logic pretrig_mode = 1'b0, sw_start = 1'b0, sw_stop = 1'b0;
    logic [31:0] pre_scans = 32'h0000_0000, post_scans = 32'h0000_0100;
    logic scan_tick = 1'b0, ref_out_bus_en = 1'b0;
    logic [2:0] start_out_sel = 3'h0, ref_out_line = 3'h0;
    logic fire = 1'b0, idle_hi = 1'b0; // far-side controls
    logic [2:0] fire_src = 3'h0;
    logic [3:0] fire_len = 4'h4;
    logic src_func, func_w, star_w, func_in_o, func_in_oe;
    logic [5:0] src_bus, bus_w, bus_o, bus_oe;
    logic seq_active, scan_enable, scan_strobe, ref_accepted, seq_done;
    logic [31:0] scan_count;
    logic [6:0] timing_sig;
    int n_mismatch = 0, n_tests = 0, n_str = 0, n_ref = 0, n_done = 0;
    int n_ts = 0, w_fo = 0, w_b3 = 0, c_fo = 0, c_b3 = 0, s0, r0, d0;
    always #2 mclk = ~mclk;
    // wire level: device wins while enabled
    assign func_w = func_in_oe ? func_in_o : src_func;
    assign bus_w = (bus_oe & bus_o) | (~bus_oe & src_bus);
    ats_sequencer ats_sequencer_inst (.mclk, .nrst, .func_in_i(func_w),
        .bus_i(bus_w), .star_i(star_w), .src_sel, .src_ext, .src_invert,
        .src_level, .pretrig_mode, .sw_start, .sw_stop, .pre_scans,
        .post_scans, .scan_tick, .start_out_sel, .ref_out_bus_en,
        .ref_out_line, .func_in_o, .func_in_oe, .bus_o, .bus_oe,
        .seq_active, .scan_enable, .scan_strobe, .ref_accepted, .seq_done,
        .scan_count, .timing_sig);
    ats_trig_src ats_trig_src_inst (.mclk, .fire, .fire_src, .fire_len,
        .idle_hi, .func_in_i(src_func), .bus_i(src_bus), .star_i(star_w));
    // tally pulses and widths away from the active edge
    always @(negedge mclk)
    begin
        n_str += scan_strobe;
        n_ref += ref_accepted;
        n_done += seq_done;
        n_ts += timing_sig[SIG_CONV];
        if (func_in_o) c_fo++;
        else if (c_fo != 0) w_fo = c_fo;
        if (!func_in_o) c_fo = 0;
        if (bus_o[3]) c_b3++;
        else if (c_b3 != 0) w_b3 = c_b3;
        if (!bus_o[3]) c_b3 = 0;
    end
    task chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s exp %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task tick(input int n);
        repeat (n)
        begin
            scan_tick = 1'b1;
            cyc(1);
            scan_tick = 1'b0;
            cyc(2);
        end
    endtask : tick
    task pulse_src(input logic [2:0] s);
        fire_src = s;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(fire_len + 6);
    endtask : pulse_src
    // posttriggered: software start, pin pulse, reference ignored, stop
    task t_post;
        start_out_sel = OUT_FUNC_IN;
        src_ext[SIG_REF] = 1'b1;
        src_sel[SIG_REF*3 +: 3] = SRC_STAR;
        cyc(2);
        chk("start pin enable", func_in_oe, 1);
        sw_start = 1'b1;
        cyc(1);
        sw_start = 1'b0;
        chk("active after start", seq_active, 1);
        chk("scan enable on", scan_enable, 1);
        s0 = n_str;
        r0 = n_ref;
        tick(2);
        chk("scan count", scan_count, post_scans - 32'h0000_0002);
        pulse_src(SRC_STAR);
        chk("ref in posttrigger", n_ref, r0);
        sw_stop = 1'b1;
        cyc(1);
        sw_stop = 1'b0;
        cyc(2);
        chk("active after stop", seq_active, 0);
        chk("scan enable off", scan_enable, 0);
        chk("stop done", n_done, 1);
        tick(1);
        chk("strobes", n_str - s0, 2);
        chk("start width", w_fo, PULSE_CYC);
        start_out_sel = OUT_NONE;
        $display("done posttriggered");
    endtask : t_post
    // every source reaches the conversion timing signal
    task t_route;
        src_ext[SIG_CONV] = 1'b1;
        for (int s = 0; s < SRC_COUNT; s++)
        begin
            src_sel[SIG_CONV*3 +: 3] = 3'(s);
            cyc(4);
            s0 = n_ts;
            pulse_src(3'(s));
            chk("routed edge", n_ts - s0, 1);
        end
        src_level[SIG_CONV] = 1'b1;
        s0 = n_ts;
        pulse_src(SRC_STAR);
        chk("routed level", n_ts - s0, fire_len);
        src_ext = 7'h00;
        $display("done routing");
    endtask : t_route
    // pretriggered: falling start on bus 1, early and late reference
    task t_pre;
        idle_hi = 1'b1;
        src_invert = 7'h7F;
        cyc(8);
        pretrig_mode = 1'b1;
        pre_scans = 32'h0000_0002;
        post_scans = 32'h0000_0003;
        src_sel[SIG_START*3 +: 3] = SRC_BUS0 + 3'h1;
        src_ext = 7'h03;
        ref_out_bus_en = 1'b1;
        ref_out_line = 3'h3;
        // start pulse goes out on bus line 5
        start_out_sel = OUT_BUS0 + 3'h5;
        d0 = n_done;
        cyc(4);
        chk("drive enables", bus_oe, 32'h0000_0028);
        pulse_src(SRC_BUS0 + 3'h1);
        chk("pre active", seq_active, 1);
        chk("start on bus", bus_o[5], 1);
        s0 = n_str;
        r0 = n_ref;
        pulse_src(SRC_STAR);
        chk("early ref", n_ref, r0);
        tick(2);
        fire_len = 4'hC;
        pulse_src(SRC_STAR);
        chk("ref taken", n_ref - r0, 1);
        chk("reload count", scan_count, post_scans);
        tick(2);
        chk("early done", n_done - d0, 0);
        tick(1);
        cyc(10);
        chk("done", n_done - d0, 1);
        chk("ended", seq_active, 0);
        chk("all scans", n_str - s0, 5);
        chk("ref width", w_b3, PULSE_CYC);
        start_out_sel = OUT_NONE;
        $display("done pretriggered");
    endtask : t_pre
    task final_report;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        cyc(16);
        nrst = 1'b1;
        cyc(2);
        chk("enables idle", {func_in_oe, bus_oe}, 0);
        t_post;
        t_route;
        t_pre;
        final_report;
    end
    // watchdog well past the expected run
    initial
    begin
        #12000;
        n_mismatch++;
        $display("watchdog expired");
        final_report;
    end
endmodule : ats_sequencer_test
